// >>> pkg/rlsq_pkg.sv
package rlsq_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ           = 250_000_000;
  localparam int unsigned SEC_BASE_S       = 1;      // time base, seconds
  localparam int unsigned TICK_CYCLES_DFLT = CLK_HZ * SEC_BASE_S;
  localparam int unsigned TICK_W           = 28;

  // ----------------------------------------------------------------
  // sizes and limits
  // ----------------------------------------------------------------
  localparam int unsigned NUM_RELAYS = 2;
  localparam logic [8:0]  MASK_MASH  = 9'h0FF;   // eight mashing steps
  localparam logic [8:0]  MASK_BOIL  = 9'h1FF;   // nine boiling events
  localparam logic [9:0]  TRIP_MAX   = 10'h3E7;  // 999 degrees
  localparam logic [9:0]  DB_MIN     = 10'h001;  // 0.1 degree
  localparam logic [9:0]  DB_MAX     = 10'h3E8;  // 100.0 degrees
  localparam logic [6:0]  PULSE_MIN  = 7'h01;
  localparam logic [6:0]  PULSE_MAX  = 7'h64;    // 100 s
  localparam logic [7:0]  HOLD_MAX   = 8'hC8;    // 200 s
  localparam logic [3:0]  STEP_FIRST = 4'h1;
  localparam logic [3:0]  STEP_LAST  = 4'h9;
  localparam logic signed [16:0] TEMP_SCALE = 17'sh0000A; // tenths/deg

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [9:0] DB_RST    = 10'h003;    // 0.3 degree
  localparam logic [6:0] PULSE_RST = 7'h05;      // 5 s
  localparam logic [7:0] HOLD_RST  = 8'h0A;      // 10 s

  // ----------------------------------------------------------------
  // register map (byte offsets) and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CFG      = 8'h00;
  localparam logic [7:0] OFF_LIM      = 8'h04;
  localparam logic [7:0] OFF_TIM      = 8'h08;
  localparam logic [7:0] RELAY_STRIDE = 8'h10;
  localparam logic [7:0] OFF_HOLD     = 8'h20;
  localparam logic [7:0] OFF_STATUS   = 8'h24;
  localparam int unsigned FUNC_LSB  = 0;
  localparam int unsigned POL_BIT   = 4;
  localparam int unsigned SHOT_BIT  = 5;
  localparam int unsigned MUTE_BIT  = 6;
  localparam int unsigned MASK_LSB  = 16;
  localparam int unsigned HIGH_LSB  = 0;
  localparam int unsigned LOW_LSB   = 16;
  localparam int unsigned DB_LSB    = 0;
  localparam int unsigned PULSE_LSB = 16;
  localparam int unsigned ST_RELAY  = 0;
  localparam int unsigned ST_HIGH   = 2;
  localparam int unsigned ST_LOW    = 4;
  localparam int unsigned ST_HOLD   = 6;
  localparam int unsigned ST_BUZZ   = 7;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FN_OFF, FN_PROCESS_TRIP, FN_MASH_STEP_SYNC, FN_BOIL_EVENT_SYNC,
    FN_BUZZER_FOLLOW, FN_TRIP_PLUS_BUZZER
  } rlsq_func_t;

  typedef struct packed {
    rlsq_func_t func;
    logic       openOnActive;   // 0 = close_on_active
    logic       singleShot;     // 0 = follow
    logic       startupMute;
    logic [8:0] stepOnMask;
    logic [9:0] highTripTemp;   // 0 = off
    logic [9:0] lowTripTemp;    // 0 = off
    logic [9:0] tripDeadband;   // tenths of a degree
    logic [6:0] pulseLenSecs;
  } rlsq_relay_cfg_t;

  localparam rlsq_relay_cfg_t CFG_RST = '{
    func: FN_OFF, openOnActive: 1'b0, singleShot: 1'b0,
    startupMute: 1'b0, stepOnMask: 9'h000, highTripTemp: 10'h000,
    lowTripTemp: 10'h000, tripDeadband: DB_RST, pulseLenSecs: PULSE_RST
  };

endpackage

// >>> rtl/rlsq_relay_seq.sv
//
// Operation
// - boil event holds timer, buzzer sounds
// - zero hold pauses until key A
// - two relays, own function selector, reset off
// - disabled relay never activates
// - process trip from high, low, or both
// - mash sync follows masked mashing steps
// - boil sync follows masked boiling events
// - buzzer follow tracks buzzer, ignores temperature
// - trip plus buzzer: buzzer adds trip, relay trip
// - polarity close or open on active
// - mask bit n-1 selects step n
// - mask max 255 mashing, 511 boiling
// - step one active from program start
// - later step active from previous finish
// - consecutive selected steps never drop out
// - boil event spans to next event
// - pulse or follow, pulse length 1-100 s
// - deadband and high low trip limits
// - startup trip suppression enable per relay
// - high trip sets above, clears below band
// - low trip sets below, clears above band
// - single shot pulse or follow trip
// - muted low trip armed after exceeding band
//
// Added by the designer: the address map and the AHB-Lite register port.
module rlsq_relay_seq
  import rlsq_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT
) (
  input  wire logic               core_clk,      // system clock
  input  wire logic               rstn,          // sync reset, low
  input  wire logic               hsel,          // ahb select
  input  wire logic [31:0]        haddr,         // ahb address
  input  wire logic [1:0]         htrans,        // ahb transfer type
  input  wire logic               hwrite,        // ahb write
  input  wire logic [2:0]         hsize,         // ahb size
  input  wire logic [31:0]        hwdata,        // ahb write data
  input  wire logic               hready,        // ahb bus ready
  output logic                    hreadyout,     // ahb slave ready
  output logic [31:0]             hrdata,        // ahb read data
  output logic                    hresp,         // ahb response
  input  wire logic signed [15:0] measuredTemp,  // tenths of degree
  input  wire logic               boilMode,      // 1 boiling, 0 mash
  input  wire logic               progRunning,   // program active
  input  wire logic [3:0]         stepIndex,     // one-based step
  input  wire logic               stepDone,      // step finished
  input  wire logic               buzzerReq,     // notification beep
  input  wire logic               boilEventHit,  // timer hit event
  input  wire logic               keyAPress,     // front key pulse
  output logic [NUM_RELAYS-1:0]   relayContact,  // 1 = closed
  output logic                    buzzerDrive,   // internal buzzer
  output logic                    boilTimerHold  // stops boil timer
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // whole degrees to tenths, signed for the temperature compare
  function automatic logic signed [16:0] scaleTemp(
    input logic [9:0] deg);
    scaleTemp = $signed({7'h00, deg}) * TEMP_SCALE;
  endfunction

  // one-based step index against a mask
  function automatic logic stepBit(input logic [8:0] mask,
                                   input logic [3:0] idx);
    logic [3:0] bitNo;
    bitNo = 4'(idx - STEP_FIRST);
    stepBit = (idx >= STEP_FIRST) && (idx <= STEP_LAST) && mask[bitNo];
  endfunction

  function automatic logic [9:0] clampTrip(input logic [9:0] v);
    clampTrip = (v > TRIP_MAX) ? TRIP_MAX : v;
  endfunction

  // ----------------------------------------------------------------
  // one second time base
  // ----------------------------------------------------------------
  logic [TICK_W-1:0] tickCnt_q, tickCnt_d;
  logic              tick_q, tick_d;

  // free-running prescaler, tick is a one-cycle enable
  always_comb begin
    tick_d    = 1'b0;
    tickCnt_d = tickCnt_q + 1'b1;
    if (tickCnt_q == TICK_W'(TICK_CYCLES - 1)) begin
      tickCnt_d = '0;
      tick_d    = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      tickCnt_q <= '0;
      tick_q    <= 1'b0;
    end else begin
      tickCnt_q <= tickCnt_d;
      tick_q    <= tick_d;
    end
  end

  // ----------------------------------------------------------------
  // ahb-lite slave and configuration registers
  // ----------------------------------------------------------------
  rlsq_relay_cfg_t       cfg_q [NUM_RELAYS];
  rlsq_relay_cfg_t       cfg_d [NUM_RELAYS];
  logic [7:0]            holdSecs_q, holdSecs_d;
  logic                  wrPend_q, wrPend_d;
  logic [7:0]            wrAddr_q, wrAddr_d;
  logic [31:0]           rdata_q, rdata_d;
  logic [31:0]           statusWord;
  logic                  accept;
  logic [NUM_RELAYS-1:0] hiAct, loAct;

  function automatic logic mapped(input logic [31:0] a);
    mapped = (a[31:8] == 24'h000000) && (a[1:0] == 2'h0) &&
             ((a[7:0] < OFF_HOLD && a[3:0] != 4'hC) ||
              a[7:0] == OFF_HOLD || a[7:0] == OFF_STATUS);
  endfunction

  assign accept = hsel && htrans[1] && hready;

  // register writes land in the data phase; reads are taken from the
  // next-state values so a read right behind a write sees new data
  always_comb begin
    logic [7:0] a;
    logic       r;
    a          = wrAddr_q;
    r          = a[4];
    cfg_d      = cfg_q;
    holdSecs_d = holdSecs_q;
    if (wrPend_q) begin
      if (a == OFF_HOLD) begin
        holdSecs_d = (hwdata[7:0] > HOLD_MAX) ? HOLD_MAX : hwdata[7:0];
      end else if (a < OFF_HOLD) begin
        case (a[3:0])
          OFF_CFG[3:0]: begin
            // unknown selector codes fall back to disabled
            cfg_d[r].func = (hwdata[FUNC_LSB+:3] > 3'(FN_TRIP_PLUS_BUZZER))
                          ? FN_OFF : rlsq_func_t'(hwdata[FUNC_LSB+:3]);
            cfg_d[r].openOnActive = hwdata[POL_BIT];
            cfg_d[r].singleShot   = hwdata[SHOT_BIT];
            cfg_d[r].startupMute  = hwdata[MUTE_BIT];
            cfg_d[r].stepOnMask   = hwdata[MASK_LSB+:9];
          end
          OFF_LIM[3:0]: begin
            cfg_d[r].highTripTemp = clampTrip(hwdata[HIGH_LSB+:10]);
            cfg_d[r].lowTripTemp  = clampTrip(hwdata[LOW_LSB+:10]);
          end
          OFF_TIM[3:0]: begin
            cfg_d[r].tripDeadband =
              (hwdata[DB_LSB+:10] < DB_MIN) ? DB_MIN :
              (hwdata[DB_LSB+:10] > DB_MAX) ? DB_MAX :
              hwdata[DB_LSB+:10];
            cfg_d[r].pulseLenSecs =
              (hwdata[PULSE_LSB+:7] < PULSE_MIN) ? PULSE_MIN :
              (hwdata[PULSE_LSB+:7] > PULSE_MAX) ? PULSE_MAX :
              hwdata[PULSE_LSB+:7];
          end
          default: ;
        endcase
      end
    end
  end

  // address phase: capture writes, prepare read data
  always_comb begin
    logic [7:0] a;
    logic       r;
    a        = haddr[7:0];
    r        = a[4];
    wrPend_d = accept && hwrite && hsize == HSIZE_WORD && mapped(haddr);
    wrAddr_d = wrPend_d ? a : wrAddr_q;
    rdata_d  = rdata_q;
    if (accept && !hwrite) begin
      rdata_d = 32'h0000_0000;                  // unmapped reads zero
      if (mapped(haddr)) begin
        if (a == OFF_HOLD) begin
          rdata_d[7:0] = holdSecs_d;
        end else if (a == OFF_STATUS) begin
          rdata_d = statusWord;
        end else begin
          case (a[3:0])
            OFF_CFG[3:0]: begin
              rdata_d[FUNC_LSB+:3] = cfg_d[r].func;
              rdata_d[POL_BIT]     = cfg_d[r].openOnActive;
              rdata_d[SHOT_BIT]    = cfg_d[r].singleShot;
              rdata_d[MUTE_BIT]    = cfg_d[r].startupMute;
              rdata_d[MASK_LSB+:9] = cfg_d[r].stepOnMask;
            end
            OFF_LIM[3:0]: begin
              rdata_d[HIGH_LSB+:10] = cfg_d[r].highTripTemp;
              rdata_d[LOW_LSB+:10]  = cfg_d[r].lowTripTemp;
            end
            OFF_TIM[3:0]: begin
              rdata_d[DB_LSB+:10]   = cfg_d[r].tripDeadband;
              rdata_d[PULSE_LSB+:7] = cfg_d[r].pulseLenSecs;
            end
            default: ;
          endcase
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_RELAYS; i++) begin
        cfg_q[i] <= CFG_RST;
      end
      holdSecs_q <= HOLD_RST;
      wrPend_q   <= 1'b0;
      wrAddr_q   <= 8'h00;
      rdata_q    <= 32'h0000_0000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end else begin
      cfg_q      <= cfg_d;
      holdSecs_q <= holdSecs_d;
      wrPend_q   <= wrPend_d;
      wrAddr_q   <= wrAddr_d;
      rdata_q    <= rdata_d;
      hreadyout  <= 1'b1;                       // zero wait states
      hresp      <= 1'b0;                       // always okay
    end
  end

  assign hrdata = rdata_q;

  // ----------------------------------------------------------------
  // boil event hold
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {HOLD_IDLE, HOLD_TIMED, HOLD_KEY} rlsq_hold_t;
  rlsq_hold_t hold_q, hold_d;
  logic [7:0] holdCnt_q, holdCnt_d;
  logic       holdOut_q, holdOut_d;

  // a new event wins over a key press in the same cycle
  always_comb begin
    hold_d    = hold_q;
    holdCnt_d = holdCnt_q;
    case (hold_q)
      HOLD_IDLE: ;
      HOLD_TIMED: begin
        if (tick_q) begin
          holdCnt_d = holdCnt_q - 1'b1;
          if (holdCnt_q == 8'h01) begin
            hold_d = HOLD_IDLE;
          end
        end
      end
      HOLD_KEY: begin
        if (keyAPress) begin
          hold_d = HOLD_IDLE;
        end
      end
      default: hold_d = HOLD_IDLE;
    endcase
    if (boilEventHit && boilMode) begin
      // one extra count so the pause never falls short a second
      hold_d    = (holdSecs_q == 8'h00) ? HOLD_KEY : HOLD_TIMED;
      holdCnt_d = holdSecs_q + 1'b1;
    end
    holdOut_d = (hold_d != HOLD_IDLE);
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      hold_q    <= HOLD_IDLE;
      holdCnt_q <= 8'h00;
      holdOut_q <= 1'b0;
    end else begin
      hold_q    <= hold_d;
      holdCnt_q <= holdCnt_d;
      holdOut_q <= holdOut_d;
    end
  end

  assign boilTimerHold = holdOut_q;

  // ----------------------------------------------------------------
  // per relay trip detection and output selection
  // ----------------------------------------------------------------
  logic [3:0]            curStep;
  logic                  notify;
  logic [NUM_RELAYS-1:0] tripOut, tripBuzz;

  // a finishing step hands over to the next in the same cycle, so a
  // run of selected steps never drops out
  assign curStep = stepDone ? 4'(stepIndex + STEP_FIRST) : stepIndex;
  assign notify  = buzzerReq || holdOut_q;

  for (genvar r = 0; r < NUM_RELAYS; r++) begin : g_relay
    logic                hiAct_q, hiAct_d, loAct_q, loAct_d;
    logic                armed_q, armed_d, trip_q, trip_d;
    logic [6:0]          pulse_q, pulse_d;
    logic                relay_q, relay_d;
    logic signed [16:0]  t, hiSet, hiClr, loSet, loClr;
    rlsq_relay_cfg_t     c;

    always_comb begin
      logic act;
      logic [8:0] mask;
      act   = 1'b0;
      mask  = 9'h000;
      c     = cfg_q[r];
      t     = {measuredTemp[15], measuredTemp};
      hiSet = scaleTemp(c.highTripTemp);
      hiClr = hiSet - $signed({7'h00, c.tripDeadband});
      loSet = scaleTemp(c.lowTripTemp);
      loClr = loSet + $signed({7'h00, c.tripDeadband});
      // high trip with deadband, zero limit means off
      hiAct_d = hiAct_q;
      if (c.highTripTemp == 10'h000) begin
        hiAct_d = 1'b0;
      end else if (t > hiSet) begin
        hiAct_d = 1'b1;
      end else if (t < hiClr) begin
        hiAct_d = 1'b0;
      end
      // low trip stays muted until the reading once clears the band
      armed_d = armed_q || (t > loClr);
      loAct_d = loAct_q;
      if (c.lowTripTemp == 10'h000 || (c.startupMute && !armed_q)) begin
        loAct_d = 1'b0;
      end else if (t < loSet) begin
        loAct_d = 1'b1;
      end else if (t > loClr) begin
        loAct_d = 1'b0;
      end
      trip_d  = hiAct_d || loAct_d;
      pulse_d = pulse_q;
      if (trip_d && !trip_q) begin
        pulse_d = c.pulseLenSecs + 1'b1;
      end else if (tick_q && pulse_q != 7'h00) begin
        pulse_d = pulse_q - 1'b1;
      end
      tripOut[r] = c.singleShot ? (pulse_q != 7'h00) : trip_q;
      // a mash mask is cut to eight steps, a boil mask to nine
      mask = c.stepOnMask & (boilMode ? MASK_BOIL : MASK_MASH);
      case (c.func)
        FN_OFF:              act = 1'b0;
        FN_PROCESS_TRIP:     act = tripOut[r];
        FN_MASH_STEP_SYNC:   act = progRunning && !boilMode &&
                                   stepBit(mask, curStep);
        FN_BOIL_EVENT_SYNC:  act = progRunning && boilMode &&
                                   stepBit(mask, curStep);
        FN_BUZZER_FOLLOW:    act = notify;
        FN_TRIP_PLUS_BUZZER: act = tripOut[r];
        default:             act = 1'b0;
      endcase
      tripBuzz[r] = (c.func == FN_TRIP_PLUS_BUZZER) && tripOut[r];
      relay_d = act ^ c.openOnActive;
    end

    always_ff @(posedge core_clk) begin
      if (!rstn) begin
        hiAct_q <= 1'b0;
        loAct_q <= 1'b0;
        armed_q <= 1'b0;
        trip_q  <= 1'b0;
        pulse_q <= 7'h00;
        relay_q <= 1'b0;
      end else begin
        hiAct_q <= hiAct_d;
        loAct_q <= loAct_d;
        armed_q <= armed_d;
        trip_q  <= trip_d;
        pulse_q <= pulse_d;
        relay_q <= relay_d;
      end
    end

    assign relayContact[r] = relay_q;
    assign hiAct[r]        = hiAct_q;
    assign loAct[r]        = loAct_q;
  end

  // ----------------------------------------------------------------
  // buzzer and status
  // ----------------------------------------------------------------
  logic buzz_q, buzz_d;

  // buzzer carries notifications plus any trip routed to it
  assign buzz_d = notify || (|tripBuzz);

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      buzz_q <= 1'b0;
    end else begin
      buzz_q <= buzz_d;
    end
  end

  assign buzzerDrive = buzz_q;

  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[ST_RELAY+:NUM_RELAYS] = relayContact;
    statusWord[ST_HIGH+:NUM_RELAYS]  = hiAct;
    statusWord[ST_LOW+:NUM_RELAYS]   = loAct;
    statusWord[ST_HOLD]              = holdOut_q;
    statusWord[ST_BUZZ]              = buzz_q;
  end

endmodule

// >>> test/rlsq_relay_seq_sva.sv
module rlsq_relay_seq_sva
  import rlsq_pkg::*;
(
  input wire logic        core_clk,      // system clock
  input wire logic        rstn,          // sync reset, low
  input wire logic        hsel,          // ahb select
  input wire logic [31:0] haddr,         // ahb address
  input wire logic [1:0]  htrans,        // ahb transfer type
  input wire logic        hwrite,        // ahb write
  input wire logic        hready,        // ahb bus ready
  input wire logic        hreadyout,     // ahb slave ready
  input wire logic [31:0] hrdata,        // ahb read data
  input wire logic        hresp,         // ahb response
  input wire logic        boilMode,      // boiling operation
  input wire logic        buzzerReq,     // notification beep
  input wire logic        boilEventHit,  // timer hit event
  input wire logic        buzzerDrive,   // internal buzzer
  input wire logic        boilTimerHold  // stops boil timer
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // bus, hold and buzzer checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // an accepted read decides what hrdata shows next
  logic rdTaken;
  assign rdTaken = hsel & htrans[1] & hready & ~hwrite;

  chk_bus_okay: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  chk_bus_ready: assert property (hreadyout == 1'b1)
    else $error("hreadyout low");
  chk_rd_unmapped: assert property (
    rdTaken && haddr == 32'h0000_000C |-> ##1 hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_rd_stands: assert property (!rdTaken |=> $stable(hrdata))
    else $error("hrdata moved without a read");
  chk_hold_start: assert property (
    boilEventHit && boilMode |=> boilTimerHold)
    else $error("hold did not start on event");
  chk_hold_cause: assert property (
    !boilTimerHold && !(boilEventHit && boilMode) |=> !boilTimerHold)
    else $error("hold started without event");
  chk_hold_buzz: assert property (boilTimerHold |=> buzzerDrive)
    else $error("buzzer silent during hold");
  chk_notify_buzz: assert property (buzzerReq |=> buzzerDrive)
    else $error("buzzer silent on notification");
endmodule

bind rlsq_relay_seq rlsq_relay_seq_sva i_chk (
  .core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .boilMode(boilMode), .buzzerReq(buzzerReq),
  .boilEventHit(boilEventHit), .buzzerDrive(buzzerDrive),
  .boilTimerHold(boilTimerHold)
);

// >>> test/rlsq_load_model.sv
module rlsq_load_model (
  input wire logic  core_clk,  // system clock
  input wire logic  contact,   // relay contact, 1 closed
  output logic [7:0] closeCnt  // pull-ins seen
);
  timeunit 1ns;
  timeprecision 100ps;
  logic prev;

  // a contactor counts fresh pull-ins only, so a dropout shows as extra
  initial begin
    closeCnt = 8'h00;
    prev = 1'b0;
  end
  always @(posedge core_clk) begin
    if (contact && !prev) closeCnt <= closeCnt + 8'h01;
    prev <= contact;
  end
endmodule

// >>> test/test_rlsq_relay_seq.sv
module test_rlsq_relay_seq
  import rlsq_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned TK = 10;  // short tick keeps holds brief
  logic core_clk, rstn, hsel, hwrite, hready, hreadyout, hresp;
  logic boilMode, progRunning, stepDone, buzzerReq, boilEventHit;
  logic keyAPress, buzzerDrive, boilTimerHold;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, relayContact;
  logic [2:0] hsize;
  logic [3:0] stepIndex;
  logic [7:0] closeCnt;
  logic signed [15:0] measuredTemp;
  logic signed [15:0] tv [8] = '{500, 501, 498, 496, 300, 299, 303, 304};
  logic [7:0] tx = 8'h66;  // expected trip, bit i for tv[i]
  logic [8:0] bm = 9'h155;
  int err_count, n_tests, cycles;

  assign hready = hreadyout;
  rlsq_relay_seq #(.TICK_CYCLES(TK)) i_dut (.core_clk(core_clk),
    .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .measuredTemp(measuredTemp), .boilMode(boilMode),
    .progRunning(progRunning), .stepIndex(stepIndex),
    .stepDone(stepDone), .buzzerReq(buzzerReq),
    .boilEventHit(boilEventHit), .keyAPress(keyAPress),
    .relayContact(relayContact), .buzzerDrive(buzzerDrive),
    .boilTimerHold(boilTimerHold));
  rlsq_load_model i_load (.core_clk(core_clk),
    .contact(relayContact[0]), .closeCnt(closeCnt));

  // ----------------------------------------------------------------
  // clock, watchdog and helpers
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // a hung handshake must still reach the verdict
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 10000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // one ahb single: address phase held until ready, then data phase
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    hsize <= HSIZE_WORD;
    do @(posedge core_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] e,
                     input string nm);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask
  task automatic step(input logic [3:0] nxt);
    stepDone <= 1'b1;
    cyc(1);
    stepDone <= 1'b0;
    stepIndex <= nxt;
    cyc(3);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rstn, hsel, hwrite, boilMode, progRunning, stepDone} = 6'h00;
    {buzzerReq, boilEventHit, keyAPress} = 3'h0;
    {haddr, hwdata, htrans, hsize, stepIndex} = '0;
    measuredTemp = 16'sh00FA;
    cyc(20);
    rstn <= 1'b1;
    cyc(2);
    rdc(OFF_CFG, 32'h0, "cfg one");
    rdc(32'h10, 32'h0, "cfg two");
    rdc(OFF_LIM, 32'h0, "limits");
    rdc(OFF_TIM, 32'h0005_0003, "timing");
    rdc(OFF_HOLD, 32'h0000_000A, "hold");
    rdc(32'h0C, 32'h0, "unmapped");
    buzzerReq <= 1'b1;
    cyc(3);
    chk("off relays", 32'h0, 32'(relayContact));
    chk("notify buzz", 32'h1, 32'(buzzerDrive));
    buzzerReq <= 1'b0;
    wr(32'h10, 32'h10);
    cyc(3);
    chk("open polarity", 32'h2, 32'(relayContact));
    wr(32'h10, 32'h4);
    buzzerReq <= 1'b1;
    cyc(3);
    chk("follow on", 32'h2, 32'(relayContact));
    buzzerReq <= 1'b0;
    cyc(3);
    chk("follow off", 32'h0, 32'(relayContact));
    // mash steps one and two selected
    wr(OFF_CFG, 32'h0003_0002);
    stepIndex <= 4'h1;
    progRunning <= 1'b1;
    cyc(3);
    chk("mash start", 32'h1, 32'(relayContact));
    step(4'h2);
    chk("mash step2", 32'h1, 32'(relayContact));
    chk("pull-ins", 32'h1, 32'(closeCnt));
    step(4'h3);
    chk("mash step3", 32'h0, 32'(relayContact));
    wr(OFF_CFG, 32'h0155_0003);
    boilMode <= 1'b1;
    for (int i = 1; i <= 9; i++) begin
      stepIndex <= 4'(i);
      cyc(3);
      chk("boil event", 32'(bm[i-1]), 32'(relayContact));
    end
    wr(OFF_CFG, 32'h01FF_0002);
    boilMode <= 1'b0;
    cyc(3);
    chk("mash mask cap", 32'h0, 32'(relayContact));
    progRunning <= 1'b0;
    // trip thresholds with deadband 0.3
    wr(OFF_LIM, 32'd50);
    wr(OFF_CFG, 32'h1);
    for (int i = 0; i < 8; i++) begin
      if (i == 4) wr(OFF_LIM, 32'h001E_0000);
      measuredTemp <= tv[i];
      cyc(4);
      chk("trip", 32'(tx[i]), 32'(relayContact));
    end
    wr(OFF_TIM, 32'h0002_0003);
    wr(OFF_LIM, 32'd50);
    wr(OFF_CFG, 32'h21);
    measuredTemp <= 16'sd501;
    cyc(4);
    chk("shot on", 32'h1, 32'(relayContact));
    cyc(12);
    chk("shot held", 32'h1, 32'(relayContact));
    cyc(30);
    chk("shot over", 32'h0, 32'(relayContact));
    wr(OFF_CFG, 32'h5);
    cyc(4);
    chk("trip buzz", 32'h1, 32'(buzzerDrive));
    chk("trip relay", 32'h1, 32'(relayContact));
    measuredTemp <= 16'sh00FA;
    // boil event hold of two seconds, then key release
    wr(OFF_HOLD, 32'h2);
    for (int k = 0; k < 2; k++) begin
      boilMode <= 1'b1;
      boilEventHit <= 1'b1;
      cyc(1);
      boilEventHit <= 1'b0;
      cyc(14);
      chk("hold on", 32'h1, 32'(boilTimerHold));
      chk("hold buzz", 32'h1, 32'(buzzerDrive));
      chk("hold follow", 32'h1, 32'(relayContact[1]));
      cyc(46);
      chk("hold end", 32'(k), 32'(boilTimerHold));
      wr(OFF_HOLD, 32'h0);
    end
    // key hold: relay two follows, buzzer on, no trip flags
    rdc(OFF_STATUS, 32'h0000_00C2, "status");
    keyAPress <= 1'b1;
    cyc(1);
    keyAPress <= 1'b0;
    cyc(3);
    chk("key resume", 32'h0, 32'(boilTimerHold));
    complete_run();
  end
endmodule
